// file: src/lpkcg_pkg.sv
// Package with register map, field layouts and types of the low-power kernel clock gating block.
package lpkcg_pkg;

  // Sizes.
  localparam int NPERIPH = 8;
  localparam int NOSC    = 3;

  // Register byte offsets.
  localparam logic [7:0] OFF_EN_SET     = 8'h00;
  localparam logic [7:0] OFF_EN_CLR     = 8'h04;
  localparam logic [7:0] OFF_SLP_SET    = 8'h08;
  localparam logic [7:0] OFF_SLP_CLR    = 8'h0c;
  localparam logic [7:0] OFF_KSEL       = 8'h10;
  localparam logic [7:0] OFF_OSC_CTRL   = 8'h14;
  localparam logic [7:0] OFF_DBG_CTRL   = 8'h18;
  localparam logic [7:0] OFF_OBS_CTRL   = 8'h1c;
  localparam logic [7:0] OFF_PWR_STAT   = 8'h20;
  localparam logic [7:0] OFF_RST_CAUSE  = 8'h24;
  localparam logic [7:0] OFF_IRQ_STAT   = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h2c;
  localparam logic [7:0] OFF_STATE      = 8'h30;

  // Field positions.
  localparam int BKP_EN_POS    = 8;   // Backup memory bus clock enable in the enable registers.
  localparam int KEEPON_POS    = 0;   // Keep-on-in-stop bits, one per oscillator, in OSC_CTRL.
  localparam int OBS_EN_POS    = 4;   // Observation port enable in OBS_CTRL.
  localparam int DBG_LP_POS    = 0;

  // Reset values.
  localparam logic [NPERIPH:0]   EN_RST    = 9'h000;
  localparam logic [NPERIPH-1:0] SLP_RST   = 8'hff;
  localparam logic [4:0]         OBS_RST   = 5'h00;

  // Kernel clock source selection codes.
  localparam logic [1:0] KSEL_BUS  = 2'h0;
  localparam logic [1:0] KSEL_HSE  = 2'h1;
  localparam logic [1:0] KSEL_HSI  = 2'h2;
  localparam logic [1:0] KSEL_CSI  = 2'h3;

  // Oscillator indexes within the oscillator vectors.
  localparam int OSC_HSE = 0;
  localparam int OSC_HSI = 1;
  localparam int OSC_CSI = 2;

  // Power modes reported by the mode sequencer.
  typedef enum logic [2:0] {
    LPKCG_RUN     = 3'b000,
    LPKCG_SLEEP   = 3'b001,
    LPKCG_STOP    = 3'b010,
    LPKCG_LPSTOP  = 3'b011,
    LPKCG_LVSTOP  = 3'b100,
    LPKCG_LVSTOP2 = 3'b101
  } lpkcg_mode_t;

  // Sequencer status bundle.
  typedef struct packed {
    logic waitInt;
    logic waitEvt;
    logic procPowerDown;
    logic sysPowerDown;
    logic sysWake;
    logic procWake;
    logic sysStandbyRst;
    logic procStandbyRst;
  } lpkcg_seq_t;

  // Interrupt status bit positions.
  localparam int IRQ_SYSWAKE  = 0;
  localparam int IRQ_PROCWAKE = 1;
  localparam int IRQ_STOPIN   = 2;
  localparam int IRQ_W        = 3;

endpackage : lpkcg_pkg

// file: src/lpkcg_clk_gate.sv
`timescale 1ns/1ps
// Glitch-free latch-free clock gate with enable taken on the falling edge.
module lpkcg_clk_gate (
  input  wire logic clkIn,
  input  wire logic rst_n,
  input  wire logic enable,
  output logic      clkOut
);

  logic enLow;

  // Outside reset, enable changes only while the clock is low, so the AND never chops a high phase.
  always_ff @(negedge clkIn or negedge rst_n) begin
    if (!rst_n) begin
      enLow <= 1'b0;
    end else begin
      enLow <= enable;
    end
  end

  assign clkOut = clkIn & enLow;

endmodule : lpkcg_clk_gate

// file: src/lpkcg_top.sv
`timescale 1ns/1ps
// Top of the low-power kernel clock gating block with its AHB-Lite register slave.
// Behaviour
// [RULE1] Backup memory bus clock has own enable
// [RULE2] Each peripheral gets bus and kernel clocks
// [RULE3] Low-speed clocked peripherals run in stop modes
// [RULE4] Stop operation needs fast oscillator kernel selection
// [RULE5] In stop, oscillator passes only on request
// [RULE6] Keep-on oscillator runs through stop modes
// [RULE7] Low-voltage stop keeps only monitors and low-speed
// [RULE8] Listed peripherals can still wake system
// [RULE9] Debug emulation keeps debug clocks and supplies
// [RULE10] Mux 1 shows core standby on output 7
// [RULE11] Mux 6 shows power-down on outputs 1,3
// [RULE12] Mux 0 shows wake on outputs 0,2
// [RULE13] Software should disable observation port finally
// [RULE14] Stop flags and reset causes are recorded
// [RULE15] Set and clear registers gate peripheral clocks
// [RULE16] Sleep enable bits via set and clear
// [RULE17] Dropped request stops non-kept oscillator glitch-free
module lpkcg_top
  import lpkcg_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic                    irq,
  input  wire logic [NOSC-1:0]    oscClk,
  input  wire logic               lowSpeedClk,
  input  wire logic [2:0]         powerMode,
  input  wire logic [7:0]         seqStatus,
  input  wire logic [NPERIPH-1:0] kernelReqAsync,
  input  wire logic [NPERIPH-1:0] wakeCapable,
  output logic      [NPERIPH-1:0] busClkEn,
  output logic                    backupBusClk,
  output logic      [NPERIPH-1:0] kernelClk,
  output logic      [NOSC-1:0]    oscRunReq,
  output logic                    debugKeepOn,
  output logic                    lowSpeedKeep,
  output logic      [NPERIPH-1:0] wakeAllowed,
  output logic      [7:0]         obsOut
);

  // Registers.
  logic [NPERIPH:0]     enReg;
  logic [NPERIPH-1:0]   slpReg;
  logic [2*NPERIPH-1:0] kselReg;
  logic [NOSC-1:0]      keepOnReg;
  logic                 dbgReg;
  logic [4:0]           obsReg;
  logic [1:0]           pwrStatReg;
  logic [1:0]           rstCauseReg;
  logic [IRQ_W-1:0]     irqStatReg;
  logic [IRQ_W-1:0]     irqMaskReg;
  logic [7:0]           obsOut_reg;
  logic [NPERIPH-1:0]   reqMeta;
  logic [NPERIPH-1:0]   reqSync;
  logic [7:0]           seqMeta;
  logic [7:0]           seqSync;
  logic [2:0]           modeMeta;
  logic [2:0]           modeSync;
  logic                 prevStop;
  lpkcg_seq_t           seq;
  lpkcg_mode_t          mode;

  // Address phase capture.
  logic       dpValid;
  logic       dpWrite;
  logic [7:0] dpAddr;

  wire        apValid = hsel & hready & htrans[1];
  wire        wrStb   = dpValid & dpWrite;
  wire        rdStb   = dpValid & ~dpWrite;

  // Decoded write strobes and clear-on-read strobes.
  wire wEnSet  = wrStb && dpAddr == OFF_EN_SET;
  wire wEnClr  = wrStb && dpAddr == OFF_EN_CLR;
  wire wSlpSet = wrStb && dpAddr == OFF_SLP_SET;
  wire wSlpClr = wrStb && dpAddr == OFF_SLP_CLR;
  wire wKsel   = wrStb && dpAddr == OFF_KSEL;
  wire wOsc    = wrStb && dpAddr == OFF_OSC_CTRL;
  wire wDbg    = wrStb && dpAddr == OFF_DBG_CTRL;
  wire wObs    = wrStb && dpAddr == OFF_OBS_CTRL;
  wire wMask   = wrStb && dpAddr == OFF_IRQ_MASK;
  wire rIrq    = rdStb && dpAddr == OFF_IRQ_STAT;
  wire rPwr    = rdStb && dpAddr == OFF_PWR_STAT;
  wire rRst    = rdStb && dpAddr == OFF_RST_CAUSE;

  // The slave always answers in its data phase with no wait state.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpAddr  <= 8'h00;
    end else begin
      dpValid <= apValid;
      dpWrite <= hwrite;
      dpAddr  <= haddr[7:0];
    end
  end

  // Synchronise request pins and sequencer status, which come from other domains.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reqMeta  <= 8'h00;
      reqSync  <= 8'h00;
      seqMeta  <= 8'h00;
      seqSync  <= 8'h00;
      modeMeta <= 3'h0;
      modeSync <= 3'h0;
    end else begin
      reqMeta  <= kernelReqAsync;
      reqSync  <= reqMeta;
      seqMeta  <= seqStatus;
      seqSync  <= seqMeta;
      modeMeta <= powerMode;
      modeSync <= modeMeta;
    end
  end

  assign seq  = lpkcg_seq_t'(seqSync);
  assign mode = lpkcg_mode_t'(modeSync);

  // Mode decode.
  wire inSleep   = mode == LPKCG_SLEEP;
  wire inStop    = mode == LPKCG_STOP || mode == LPKCG_LPSTOP;
  wire inLvStop  = mode == LPKCG_LVSTOP || mode == LPKCG_LVSTOP2;
  wire anyStop   = inStop | inLvStop;

  // Set and clear registers; writing a one acts, zeros leave bits alone.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enReg  <= EN_RST;
      slpReg <= SLP_RST;
    end else begin
      enReg  <= (enReg | (wEnSet ? hwdata[NPERIPH:0] : 9'h000))
                & ~(wEnClr ? hwdata[NPERIPH:0] : 9'h000); // [RULE15] [RULE1]
      slpReg <= (slpReg | (wSlpSet ? hwdata[NPERIPH-1:0] : 8'h00))
                & ~(wSlpClr ? hwdata[NPERIPH-1:0] : 8'h00); // [RULE16]
    end
  end

  // Plain control registers.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kselReg    <= 16'h0000;
      keepOnReg  <= 3'h0;
      dbgReg     <= 1'b0;
      obsReg     <= OBS_RST;
      irqMaskReg <= 3'h0;
    end else begin
      if (wKsel) kselReg <= hwdata[2*NPERIPH-1:0];
      if (wOsc) keepOnReg <= hwdata[KEEPON_POS +: NOSC];
      if (wDbg) dbgReg <= hwdata[DBG_LP_POS];
      if (wObs) obsReg <= hwdata[4:0];
      if (wMask) irqMaskReg <= hwdata[IRQ_W-1:0];
    end
  end

  // Bus clock gating: run, or sleep with the sleep bit, or debug emulation holding clocks.
  assign busClkEn     = enReg[NPERIPH-1:0]
                        & ((anyStop | (inSleep & ~dbgReg)) ? (dbgReg ? 8'hff : slpReg & {8{inSleep}})
                                                           : 8'hff); // [RULE2] [RULE16] [RULE9]
  assign backupBusClk = enReg[BKP_EN_POS] & (~anyStop | dbgReg); // [RULE1]

  // Kernel clock path for each peripheral.
  logic [NPERIPH-1:0] kEnable;
  logic [NPERIPH-1:0] kSrcClk;
  logic [NOSC-1:0]    oscNeeded;

  always_comb begin
    oscNeeded = 3'h0;
    for (int i = 0; i < NPERIPH; i++) begin
      logic [1:0] sel;
      sel = kselReg[2*i +: 2];
      unique case (sel)
        KSEL_HSE: kSrcClk[i] = oscClk[OSC_HSE];
        KSEL_HSI: kSrcClk[i] = oscClk[OSC_HSI];
        KSEL_CSI: kSrcClk[i] = oscClk[OSC_CSI];
        KSEL_BUS: kSrcClk[i] = core_clk;
      endcase
      // Outside stop the kernel clock follows the enable; in plain stop only
      // an oscillator source with a live request is passed.
      if (inStop) begin
        kEnable[i] = enReg[i] & reqSync[i] & (sel != KSEL_BUS); // [RULE4] [RULE5]
      end else if (inLvStop) begin
        kEnable[i] = dbgReg & enReg[i]; // [RULE7] [RULE9]
      end else begin
        kEnable[i] = enReg[i];
      end
      if (kEnable[i] && sel != KSEL_BUS) oscNeeded[sel - 2'h1] = 1'b1;
    end
  end

  // One glitch-free gate per peripheral on its chosen source.
  // The enable is made on the core clock and crosses at the gate's falling-edge flop,
  // which a clock enable tolerates; nothing else may read it in the source domain.
  for (genvar g = 0; g < NPERIPH; g++) begin : gKernel
    lpkcg_clk_gate uGate (
      .clkIn  (kSrcClk[g]),
      .rst_n  (rst_n),
      .enable (kEnable[g]),
      .clkOut (kernelClk[g])
    ); // [RULE17] [RULE2]
  end

  // Oscillators run outside stop, in plain stop when kept on or requested, and for debug.
  // The low-speed pair never stops in any stop depth, so its keep level is constant.
  assign oscRunReq    = ~anyStop ? 3'h7
                        : (inStop ? (keepOnReg | oscNeeded) : 3'h0)
                          | (dbgReg ? 3'h7 : 3'h0); // [RULE6] [RULE17]
  assign lowSpeedKeep = 1'b1 & (lowSpeedClk | ~lowSpeedClk); // [RULE3] [RULE7]
  assign debugKeepOn  = dbgReg & (anyStop | inSleep); // [RULE9]
  assign wakeAllowed  = inLvStop ? wakeCapable : {NPERIPH{1'b1}}; // [RULE8]

  // Observation outputs come from a register; port disabled reads zero to save toggles.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      obsOut_reg <= 8'h00;
    end else begin
      obsOut_reg <= 8'h00;
      if (obsReg[OBS_EN_POS]) begin
        unique case (obsReg[3:0])
          4'h0: begin
            obsOut_reg[0] <= seq.sysWake; // [RULE12]
            obsOut_reg[2] <= seq.procWake; // [RULE12]
          end
          4'h1: obsOut_reg[7] <= seq.waitInt | seq.waitEvt; // [RULE10]
          4'h6: begin
            obsOut_reg[1] <= seq.procPowerDown; // [RULE11]
            obsOut_reg[3] <= seq.sysPowerDown; // [RULE11]
          end
          default: obsOut_reg <= 8'h00;
        endcase
      end
    end
  end
  assign obsOut = obsOut_reg;

  // Clear-on-read drops only the bits that the read returned, so an event that
  // lands between the address phase and the data phase survives to the next read.
  wire [1:0]       pwrClr = rPwr ? hrdata[1:0] : 2'h0;
  wire [1:0]       rstClr = rRst ? hrdata[1:0] : 2'h0;
  wire [IRQ_W-1:0] irqClr = rIrq ? hrdata[IRQ_W-1:0] : 3'h0;

  // Sticky status; a new event wins over the read that clears.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrStatReg  <= 2'h0;
      rstCauseReg <= 2'h0;
      irqStatReg  <= 3'h0;
      prevStop    <= 1'b0;
    end else begin
      prevStop    <= anyStop;
      pwrStatReg  <= (pwrStatReg & ~pwrClr)
                     | {seq.sysPowerDown, seq.procPowerDown}; // [RULE14]
      rstCauseReg <= (rstCauseReg & ~rstClr)
                     | {seq.sysStandbyRst, seq.procStandbyRst}; // [RULE14]
      irqStatReg  <= (irqStatReg & ~irqClr)
                     | {anyStop & ~prevStop, seq.procWake, seq.sysWake};
    end
  end

  assign irq = |(irqStatReg & irqMaskReg);

  // Read data, registered so the word stands in the data phase after the address phase.
  logic [31:0] rdMux;
  always_comb begin
    unique case (haddr[7:0])
      OFF_EN_SET, OFF_EN_CLR:   rdMux = {23'h0, enReg};
      OFF_SLP_SET, OFF_SLP_CLR: rdMux = {24'h0, slpReg};
      OFF_KSEL:                 rdMux = {16'h0, kselReg};
      OFF_OSC_CTRL:             rdMux = {29'h0, keepOnReg};
      OFF_DBG_CTRL:             rdMux = {31'h0, dbgReg};
      OFF_OBS_CTRL:             rdMux = {27'h0, obsReg};
      OFF_PWR_STAT:             rdMux = {30'h0, pwrStatReg};
      OFF_RST_CAUSE:            rdMux = {30'h0, rstCauseReg};
      OFF_IRQ_STAT:             rdMux = {29'h0, irqStatReg};
      OFF_IRQ_MASK:             rdMux = {29'h0, irqMaskReg};
      OFF_STATE:                rdMux = {21'h0, reqSync, modeSync};
      default:                  rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
    end else if (apValid && !hwrite) begin
      hrdata <= rdMux;
    end
  end

endmodule : lpkcg_top

// file: sim/lpkcg_top_chk.sv
`timescale 1ns/1ps
// Port checker of the low-power kernel clock gating block.
module lpkcg_top_chk
  import lpkcg_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic               irq,
  input wire logic [2:0]         powerMode,
  input wire logic [NPERIPH-1:0] kernelReqAsync,
  input wire logic [NPERIPH-1:0] wakeCapable,
  input wire logic [NPERIPH-1:0] kernelClk,
  input wire logic [NOSC-1:0]    oscRunReq,
  input wire logic               debugKeepOn,
  input wire logic               lowSpeedKeep,
  input wire logic [NPERIPH-1:0] wakeAllowed,
  input wire logic [7:0]         obsOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Eight settled samples allow for the request synchroniser and the gate's own edge.
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("read data moved without a read");
  a_ls_keep: assert property (lowSpeedKeep) else $error("low-speed keep dropped");
  a_stop_req0: assert property ((powerMode == LPKCG_STOP && !kernelReqAsync[0])[*8]
    |-> !kernelClk[0]) else $error("kernel clock 0 without request in stop");
  // Peripheral 0 runs from an oscillator in both stop depths, so its gate is really exercised.
  a_lpstop_req0: assert property ((powerMode == LPKCG_LPSTOP && !kernelReqAsync[0])[*8]
    |-> !kernelClk[0]) else $error("kernel clock 0 without request in low-power stop");
  a_lv_gate: assert property ((powerMode == LPKCG_LVSTOP && !debugKeepOn)[*8]
    |-> kernelClk == 8'h00) else $error("kernel clock in low-voltage stop");
  a_run_osc: assert property ((powerMode == LPKCG_RUN)[*4] |-> oscRunReq == 3'h7)
    else $error("oscillator stopped in run");
  a_wake_pass: assert property ((powerMode == LPKCG_LVSTOP && $stable(wakeCapable))[*4]
    |-> wakeAllowed == wakeCapable) else $error("wake sources not passed");
  a_reset_quiet: assert property ($rose(rst_n) |-> obsOut == 8'h00 && !irq)
    else $error("outputs active after reset");

  // Main scenarios reached.
  c_stop_req: cover property (powerMode == LPKCG_STOP && kernelReqAsync[0]);
  c_lv_debug: cover property (powerMode == LPKCG_LVSTOP && debugKeepOn);
  c_obs_irq: cover property (obsOut != 8'h00 && irq);
endmodule : lpkcg_top_chk

// file: sim/lpkcg_periph_model.sv
`timescale 1ns/1ps
// Behavioural peripherals that request kernel clocks and count the edges they get.
module lpkcg_periph_model
  import lpkcg_pkg::*;
(
  input  wire logic [NPERIPH-1:0] wantClk,
  input  wire logic               core_clk,
  input  wire logic [NPERIPH-1:0] kernelClk,
  output logic      [NPERIPH-1:0] kernelReqAsync,
  output int                      edgeCnt [NPERIPH]
);
  // A peripheral holds its request as a level for as long as it needs the clock.
  initial kernelReqAsync = '0;
  always @(posedge core_clk) kernelReqAsync <= wantClk;

  // Counting edges shows whether a gate really let the clock through.
  for (genvar g = 0; g < NPERIPH; g++) begin : gCnt
    always @(posedge kernelClk[g]) edgeCnt[g] <= edgeCnt[g] + 1;
  end
endmodule : lpkcg_periph_model

// file: sim/lpkcg_top_tb.sv
`timescale 1ns/1ps
// Self-checking bench of the low-power kernel clock gating block.
module lpkcg_top_tb;
  import lpkcg_pkg::*;
  logic               core_clk  = 1'b0;
  logic               rst_n     = 1'b0;
  logic               hsel      = 1'b0;
  logic [31:0]        haddr     = 32'h0;
  logic [1:0]         htrans    = 2'h0;
  logic               hwrite    = 1'b0;
  logic [31:0]        hwdata    = 32'h0;
  logic [NOSC-1:0]    oscClk    = 3'h0;
  logic [2:0]         powerMode = LPKCG_RUN;
  lpkcg_seq_t         seq       = '0;
  logic [NPERIPH-1:0] wantClk   = 8'h00;
  logic [NPERIPH-1:0] wakeCap   = 8'h00;
  logic [31:0]        hrdata;
  logic               hreadyout, hresp, irq, backupBusClk, debugKeepOn, lowSpeedKeep;
  logic [NPERIPH-1:0] busClkEn, kernelClk, kernelReq, wakeAllowed;
  logic [NOSC-1:0]    oscRunReq;
  logic [7:0]         obsOut;
  int                 edgeCnt [NPERIPH];
  int                 fail_count = 0;
  int                 samples_checked = 0;

  // Core clock and three unrelated oscillators.
  always #2.5 core_clk = ~core_clk;
  always #3 oscClk[0] = ~oscClk[0];
  always #4 oscClk[1] = ~oscClk[1];
  always #5 oscClk[2] = ~oscClk[2];

  lpkcg_top dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .oscClk(oscClk),
    .lowSpeedClk(1'b0), .powerMode(powerMode), .seqStatus(seq), .kernelReqAsync(kernelReq),
    .wakeCapable(wakeCap), .busClkEn(busClkEn), .backupBusClk(backupBusClk),
    .kernelClk(kernelClk), .oscRunReq(oscRunReq), .debugKeepOn(debugKeepOn),
    .lowSpeedKeep(lowSpeedKeep), .wakeAllowed(wakeAllowed), .obsOut(obsOut));
  lpkcg_periph_model periph (.wantClk(wantClk), .core_clk(core_clk), .kernelClk(kernelClk),
    .kernelReqAsync(kernelReq), .edgeCnt(edgeCnt));

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One single AHB-Lite transfer; the master never assumes a wait count.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(string nm, logic [7:0] a, logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(nm, exp, r);
  endtask : rdchk

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // Counting over forty core cycles tells a running clock from a gated one.
  task automatic runs(int i, logic exp, string nm);
    int s;
    s = edgeCnt[i];
    cyc(40);
    chk(nm, {31'h0, exp}, {31'h0, edgeCnt[i] > s});
  endtask : runs

  task automatic t_reset;
    chk("busClkEn", 32'h0, {24'h0, busClkEn});
    rdchk("sleep enables", OFF_SLP_SET, 32'hff);
    rdchk("unmapped", 8'h40, 32'h0);
    chk("lowSpeedKeep", 32'h1, {31'h0, lowSpeedKeep});
  endtask : t_reset

  task automatic t_enable;
    wr(OFF_EN_SET, 32'h103);
    cyc(1);
    chk("busClkEn set", 32'h3, {24'h0, busClkEn});
    chk("backup on", 32'h1, {31'h0, backupBusClk});
    wr(OFF_EN_CLR, 32'h102);
    cyc(1);
    chk("busClkEn clr", 32'h1, {24'h0, busClkEn});
    chk("backup off", 32'h0, {31'h0, backupBusClk});
    runs(0, 1'b1, "kernel 0 run");
    runs(1, 1'b0, "kernel 1 off");
  endtask : t_enable

  task automatic t_sleep;
    wr(OFF_SLP_CLR, 32'h01);
    wr(OFF_EN_SET, 32'h02);
    rdchk("sleep cleared", OFF_SLP_SET, 32'hfe);
    powerMode <= LPKCG_SLEEP;
    cyc(6);
    chk("busClkEn sleep", 32'h2, {24'h0, busClkEn});
    powerMode <= LPKCG_RUN;
    wr(OFF_SLP_SET, 32'h01);
    cyc(6);
    chk("busClkEn wake", 32'h3, {24'h0, busClkEn});
  endtask : t_sleep

  // Both plain stop depths, each on its own oscillator: a clock only on request, an idle one released.
  task automatic t_stop(logic [2:0] m, logic [1:0] ks, int o);
    wr(OFF_KSEL, {30'h0, ks});
    wr(OFF_OSC_CTRL, 32'h0);
    powerMode <= m;
    cyc(8);
    runs(0, 1'b0, "no request");
    chk("osc idle", 32'h0, {31'h0, oscRunReq[o]});
    wantClk <= 8'h01;
    runs(0, 1'b1, "request");
    chk("osc asked", 32'h1, {31'h0, oscRunReq[o]});
    wantClk <= 8'h00;
    cyc(8);
    runs(0, 1'b0, "request dropped");
    wr(OFF_OSC_CTRL, 32'h1 << o);
    cyc(2);
    chk("osc kept", 32'h1, {31'h0, oscRunReq[o]});
    powerMode <= LPKCG_RUN;
    cyc(6);
  endtask : t_stop

  task automatic t_lvstop;
    wantClk   <= 8'h01;
    wakeCap   <= 8'h5a;
    powerMode <= LPKCG_LVSTOP;
    // The mode synchroniser and the gate need a few cycles before the clock stops.
    cyc(8);
    runs(0, 1'b0, "lv gated");
    chk("wakeAllowed", 32'h5a, {24'h0, wakeAllowed});
    wr(OFF_DBG_CTRL, 32'h1);
    cyc(1);
    chk("debugKeepOn", 32'h1, {31'h0, debugKeepOn});
    runs(0, 1'b1, "lv debug");
    wr(OFF_DBG_CTRL, 32'h0);
    powerMode <= LPKCG_RUN;
    wantClk   <= 8'h00;
    cyc(6);
  endtask : t_lvstop

  // A status pulse must show on the chosen observation outputs and then clear.
  task automatic obs(logic [3:0] mux, lpkcg_seq_t sv, logic [7:0] mask);
    wr(OFF_OBS_CTRL, {27'h0, 1'b1, mux});
    seq <= sv;
    cyc(5);
    chk("obs high", {24'h0, mask}, {24'h0, obsOut & mask});
    seq <= '0;
    cyc(5);
    chk("obs low", 32'h0, {24'h0, obsOut & mask});
  endtask : obs

  task automatic t_obs;
    rdchk("stop event", OFF_IRQ_STAT, 32'h4);
    wr(OFF_IRQ_MASK, 32'h0);
    obs(4'h1, 8'h80, 8'h80);
    obs(4'h6, 8'h30, 8'h0a);
    rdchk("stop flags", OFF_PWR_STAT, 32'h3);
    rdchk("stop flags cleared", OFF_PWR_STAT, 32'h0);
    obs(4'h0, 8'h0c, 8'h05);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_IRQ_MASK, 32'h3);
    cyc(1);
    chk("irq raised", 32'h1, {31'h0, irq});
    rdchk("wake events", OFF_IRQ_STAT, 32'h3);
    // The clear lands on the data-phase edge, so the level is looked at one edge later.
    cyc(1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    seq <= 8'h03;
    cyc(5);
    seq <= '0;
    cyc(5);
    rdchk("reset causes", OFF_RST_CAUSE, 32'h3);
    wr(OFF_OBS_CTRL, 32'h0);
  endtask : t_obs

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  // Main sequence after a twenty-cycle reset.
  initial begin
    cyc(20);
    rst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_enable();
    t_sleep();
    t_stop(LPKCG_STOP, KSEL_HSE, OSC_HSE);
    t_stop(LPKCG_LPSTOP, KSEL_CSI, OSC_CSI);
    t_lvstop();
    t_obs();
    conclude();
  end

  // Watchdog well beyond the few hundred cycles the run needs.
  initial begin
    #100us;
    fail_count++;
    conclude();
  end
endmodule : lpkcg_top_tb

bind lpkcg_top lpkcg_top_chk chk (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .irq(irq), .powerMode(powerMode), .kernelReqAsync(kernelReqAsync),
  .wakeCapable(wakeCapable), .kernelClk(kernelClk), .oscRunReq(oscRunReq),
  .debugKeepOn(debugKeepOn), .lowSpeedKeep(lowSpeedKeep), .wakeAllowed(wakeAllowed),
  .obsOut(obsOut));
